// File: src/pcc_pkg.sv
// Package: constants and carriers for the PWM counter-compare stage
package pcc_pkg;
   localparam int CW = 16;
   // Register offsets
   localparam logic [7:0] OFS_COMPARE_CONTROL = 8'h0e;
   localparam logic [7:0] OFS_COMPARE_A_FINE_EXTENSION = 8'h10;
   localparam logic [7:0] OFS_COMPARE_A_VALUE = 8'h12;
   localparam logic [7:0] OFS_COMPARE_B_VALUE = 8'h14;
   // Compare control field positions
   localparam int POS_LOAD_A = 0;
   localparam int POS_LOAD_B = 2;
   localparam int POS_IMM_A = 4;
   localparam int POS_IMM_B = 6;
   localparam int POS_SHADOW_FULL_A = 8;
   localparam int POS_SHADOW_FULL_B = 9;
   // Reset values
   localparam logic [15:0] RST_COMPARE_CONTROL = 16'h0000;
   localparam logic [15:0] RST_COMPARE = 16'h0000;
   localparam logic [15:0] RST_FINE = 16'h0000;
   // Load point encoding
   localparam logic [1:0] LOAD_ZERO = 2'h0;
   localparam logic [1:0] LOAD_PERIOD = 2'h1;
   localparam logic [1:0] LOAD_BOTH = 2'h2;
   localparam logic [1:0] LOAD_FREEZE = 2'h3;

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } pcc_bus_req_t;

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] period;
      logic count_up;
      logic tick;
   } pcc_time_base_t;

   typedef struct packed {
      logic match_a_event;
      logic match_b_event;
      logic zero_match_event;
      logic period_match_event;
      logic count_up;
   } pcc_events_t;
endpackage : pcc_pkg

// File: src/pcc_counter_compare.sv
// Module: counter-compare stage with shadowed compare A and B values
module pcc_counter_compare #(
   parameter bit HAS_FINE = 1'b1
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire pcc_pkg::pcc_bus_req_t i_bus,
   output logic [15:0] o_rdata,
   input wire pcc_pkg::pcc_time_base_t i_tb,
   output pcc_pkg::pcc_events_t o_events,
   output logic [15:0] o_fine_a
);
   logic [1:0] load_a_q;
   logic [1:0] load_b_q;
   logic imm_a_q;
   logic imm_b_q;
   logic [15:0] act_a_q;
   logic [15:0] act_b_q;
   logic [15:0] shd_a_q;
   logic [15:0] shd_b_q;
   logic full_a_q;
   logic full_b_q;
   logic [15:0] fine_q;
   logic is_zero;
   logic is_period;
   logic ld_a;
   logic ld_b;
   logic wr_ctl;
   logic wr_a;
   logic wr_b;
   logic wr_fine;

   function automatic logic load_due(input logic [1:0] mode, input logic z, input logic p);
      logic r;
      r = 1'b0;
      case (mode)
         pcc_pkg::LOAD_ZERO: r = z;
         pcc_pkg::LOAD_PERIOD: r = p;
         pcc_pkg::LOAD_BOTH: r = z | p;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : load_due

   assign is_zero = i_tb.tick && (i_tb.count == 16'h0000);
   assign is_period = i_tb.tick && (i_tb.count == i_tb.period);
   assign ld_a = !imm_a_q && load_due(load_a_q, is_zero, is_period);
   assign ld_b = !imm_b_q && load_due(load_b_q, is_zero, is_period);

   always_comb begin
      wr_ctl = 1'b0;
      wr_a = 1'b0;
      wr_b = 1'b0;
      wr_fine = 1'b0;
      if (i_bus.wr && i_bus.addr == pcc_pkg::OFS_COMPARE_CONTROL) begin
         wr_ctl = 1'b1;
      end else if (i_bus.wr && i_bus.addr == pcc_pkg::OFS_COMPARE_A_VALUE) begin
         wr_a = 1'b1;
      end else if (i_bus.wr && i_bus.addr == pcc_pkg::OFS_COMPARE_B_VALUE) begin
         wr_b = 1'b1;
      end else if (i_bus.wr && i_bus.addr == pcc_pkg::OFS_COMPARE_A_FINE_EXTENSION) begin
         wr_fine = HAS_FINE;
      end
   end

   // Compare control
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         load_a_q <= pcc_pkg::RST_COMPARE_CONTROL[pcc_pkg::POS_LOAD_A +: 2];
         load_b_q <= pcc_pkg::RST_COMPARE_CONTROL[pcc_pkg::POS_LOAD_B +: 2];
         imm_a_q <= pcc_pkg::RST_COMPARE_CONTROL[pcc_pkg::POS_IMM_A];
         imm_b_q <= pcc_pkg::RST_COMPARE_CONTROL[pcc_pkg::POS_IMM_B];
      end else if (wr_ctl) begin
         load_a_q <= i_bus.wdata[pcc_pkg::POS_LOAD_A +: 2];
         load_b_q <= i_bus.wdata[pcc_pkg::POS_LOAD_B +: 2];
         imm_a_q <= i_bus.wdata[pcc_pkg::POS_IMM_A];
         imm_b_q <= i_bus.wdata[pcc_pkg::POS_IMM_B];
      end
   end

   // Compare A copies
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         act_a_q <= pcc_pkg::RST_COMPARE;
         shd_a_q <= pcc_pkg::RST_COMPARE;
         full_a_q <= 1'b0;
      end else begin
         if (wr_a && imm_a_q) begin
            act_a_q <= i_bus.wdata;
         end else if (ld_a) begin
            act_a_q <= shd_a_q;
         end
         if (wr_a && !imm_a_q) begin
            shd_a_q <= i_bus.wdata;
            full_a_q <= 1'b1;
         end else if (ld_a) begin
            full_a_q <= 1'b0;
         end
      end
   end

   // Compare B copies
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         act_b_q <= pcc_pkg::RST_COMPARE;
         shd_b_q <= pcc_pkg::RST_COMPARE;
         full_b_q <= 1'b0;
      end else begin
         if (wr_b && imm_b_q) begin
            act_b_q <= i_bus.wdata;
         end else if (ld_b) begin
            act_b_q <= shd_b_q;
         end
         if (wr_b && !imm_b_q) begin
            shd_b_q <= i_bus.wdata;
            full_b_q <= 1'b1;
         end else if (ld_b) begin
            full_b_q <= 1'b0;
         end
      end
   end

   // Fine extension, written directly on a bus write, not shadowed with compare A
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         fine_q <= pcc_pkg::RST_FINE;
      end else if (wr_fine) begin
         fine_q <= i_bus.wdata;
      end
   end
   assign o_fine_a = HAS_FINE ? fine_q : 16'h0000;

   // Read data, one cycle after the read strobe
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         o_rdata <= 16'h0000;
      end else if (!i_bus.rd) begin
         o_rdata <= 16'h0000;
      end else if (i_bus.addr == pcc_pkg::OFS_COMPARE_CONTROL) begin
         o_rdata <= {6'h00, full_b_q, full_a_q, 1'b0, imm_b_q, 1'b0, imm_a_q,
                     load_b_q, load_a_q};
      end else if (i_bus.addr == pcc_pkg::OFS_COMPARE_A_VALUE) begin
         o_rdata <= imm_a_q ? act_a_q : shd_a_q;
      end else if (i_bus.addr == pcc_pkg::OFS_COMPARE_B_VALUE) begin
         o_rdata <= imm_b_q ? act_b_q : shd_b_q;
      end else if (i_bus.addr == pcc_pkg::OFS_COMPARE_A_FINE_EXTENSION) begin
         o_rdata <= HAS_FINE ? fine_q : 16'h0000;
      end else begin
         o_rdata <= 16'h0000;
      end
   end

   // Events registered every clock, raised only on a time-base tick, matches from active values only
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         o_events <= '0;
      end else begin
         o_events.match_a_event <= i_tb.tick && (i_tb.count == act_a_q);
         o_events.match_b_event <= i_tb.tick && (i_tb.count == act_b_q);
         o_events.zero_match_event <= is_zero;
         o_events.period_match_event <= is_period;
         o_events.count_up <= i_tb.count_up;
      end
   end
   // Counter jumps from sync just pass through; no attempt to recover missed matches
   // Up-count mode gives one match per pass; up-down mode matches values between zero and period twice per pass

   event_a_ok_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_tb.tick && i_tb.count == act_a_q)
      |=> o_events.match_a_event)
      else $error("match a missed");
   event_b_ok_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_tb.tick && i_tb.count == act_b_q)
      |=> o_events.match_b_event)
      else $error("match b missed");
   event_a_only_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      o_events.match_a_event
      |-> $past(i_tb.tick) && $past(i_tb.count) == $past(act_a_q))
      else $error("spurious match a");
   event_b_only_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      o_events.match_b_event
      |-> $past(i_tb.tick) && $past(i_tb.count) == $past(act_b_q))
      else $error("spurious match b");
   no_tick_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      !i_tb.tick
      |=> !o_events.match_a_event && !o_events.match_b_event)
      else $error("match without tick");
   zero_event_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_tb.tick && i_tb.count == 16'h0000)
      |=> o_events.zero_match_event)
      else $error("zero event missed");
   period_event_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_tb.tick && i_tb.count == i_tb.period)
      |=> o_events.period_match_event)
      else $error("period event missed");
   direction_fwd_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      $past(i_rst_b)
      |-> o_events.count_up == $past(i_tb.count_up))
      else $error("direction not forwarded");

   load_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (!imm_a_q && load_a_q == pcc_pkg::LOAD_ZERO && is_zero && !wr_a)
      |=> act_a_q == $past(shd_a_q))
      else $error("zero load of a failed");
   load_zero_b_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (!imm_b_q && load_b_q == pcc_pkg::LOAD_ZERO && is_zero && !wr_b)
      |=> act_b_q == $past(shd_b_q))
      else $error("zero load of b failed");
   load_period_a_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (!imm_a_q && load_a_q == pcc_pkg::LOAD_PERIOD && is_period && !wr_a)
      |=> act_a_q == $past(shd_a_q))
      else $error("period load of a failed");
   load_period_b_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (!imm_b_q && load_b_q == pcc_pkg::LOAD_PERIOD && is_period && !wr_b)
      |=> act_b_q == $past(shd_b_q))
      else $error("period load of b failed");
   load_both_b_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (!imm_b_q && load_b_q == pcc_pkg::LOAD_BOTH && (is_zero || is_period) && !wr_b)
      |=> act_b_q == $past(shd_b_q))
      else $error("double load of b failed");
   freeze_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (load_a_q == pcc_pkg::LOAD_FREEZE && !wr_a)
      |=> $stable(act_a_q))
      else $error("frozen a changed");
   freeze_hold_b_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (load_b_q == pcc_pkg::LOAD_FREEZE && !wr_b)
      |=> $stable(act_b_q))
      else $error("frozen b changed");
   no_tick_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (!i_tb.tick && !wr_a)
      |=> $stable(act_a_q))
      else $error("a loaded without tick");
   no_tick_hold_b_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (!i_tb.tick && !wr_b)
      |=> $stable(act_b_q))
      else $error("b loaded without tick");
   pending_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (ld_a && !wr_a)
      |=> !full_a_q)
      else $error("pending a not cleared");

   shadow_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (wr_a && !imm_a_q && !ld_a)
      |=> $stable(act_a_q) && shd_a_q == $past(i_bus.wdata))
      else $error("shadow write reached active");
   shadow_write_b_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (wr_b && !imm_b_q && !ld_b)
      |=> $stable(act_b_q) && shd_b_q == $past(i_bus.wdata))
      else $error("shadow write of b reached active");
   shadow_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      !wr_a
      |=> $stable(shd_a_q))
      else $error("shadow a changed");
   shadow_hold_b_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      !wr_b
      |=> $stable(shd_b_q))
      else $error("shadow b changed");
   pending_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (wr_a && !imm_a_q)
      |=> full_a_q)
      else $error("pending a not set");
   immediate_a_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (wr_a && imm_a_q)
      |=> act_a_q == $past(i_bus.wdata))
      else $error("immediate write of a lost");
   immediate_b_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (wr_b && imm_b_q)
      |=> act_b_q == $past(i_bus.wdata))
      else $error("immediate write of b lost");
   imm_hold_a_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (imm_a_q && !wr_a)
      |=> $stable(act_a_q))
      else $error("a loaded in immediate mode");
   imm_hold_b_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (imm_b_q && !wr_b)
      |=> $stable(act_b_q))
      else $error("b loaded in immediate mode");

   read_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      !i_bus.rd
      |=> o_rdata == 16'h0000)
      else $error("read data without strobe");
   read_a_path_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_bus.rd && i_bus.addr == pcc_pkg::OFS_COMPARE_A_VALUE)
      |=> o_rdata == $past(imm_a_q ? act_a_q : shd_a_q))
      else $error("wrong copy of a read");
   read_b_path_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_bus.rd && i_bus.addr == pcc_pkg::OFS_COMPARE_B_VALUE)
      |=> o_rdata == $past(imm_b_q ? act_b_q : shd_b_q))
      else $error("wrong copy of b read");
   read_ctl_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      (i_bus.rd && i_bus.addr == pcc_pkg::OFS_COMPARE_CONTROL)
      |=> o_rdata[pcc_pkg::POS_LOAD_A +: 2] == $past(load_a_q)
         && o_rdata[pcc_pkg::POS_LOAD_B +: 2] == $past(load_b_q))
      else $error("load points read wrong");
   ctl_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      wr_ctl
      |=> load_a_q == $past(i_bus.wdata[pcc_pkg::POS_LOAD_A +: 2])
         && imm_a_q == $past(i_bus.wdata[pcc_pkg::POS_IMM_A]))
      else $error("control write lost");
   ctl_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      !wr_ctl
      |=> $stable(load_a_q) && $stable(load_b_q)
         && $stable(imm_a_q) && $stable(imm_b_q))
      else $error("control changed without write");
   fine_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      wr_fine
      |=> o_fine_a == $past(i_bus.wdata))
      else $error("fine write lost");
   fine_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      !wr_fine
      |=> $stable(fine_q))
      else $error("fine changed without write");
   reset_shadow_a: assert property (@(posedge i_sys_clk)
      !i_rst_b
      |=> !imm_a_q && !imm_b_q)
      else $error("shadow not enabled after reset");
   reset_clear_a: assert property (@(posedge i_sys_clk)
      !i_rst_b
      |=> act_a_q == 16'h0000 && act_b_q == 16'h0000 && !full_a_q && !full_b_q)
      else $error("compare copies not cleared");

   cov_match_a_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      o_events.match_a_event);
   cov_load_a_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) ld_a && full_a_q);
   cov_imm_b_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) wr_b && imm_b_q);
   cov_both_b_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      ld_b && load_b_q == pcc_pkg::LOAD_BOTH && is_period);
   cov_both_c: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      o_events.match_a_event && o_events.match_b_event);
endmodule : pcc_counter_compare

// File: dv/pcc_time_base_model.sv
// Time-base counter model that feeds the compare stage
module pcc_time_base_model (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic [1:0] i_mode,
   input wire logic [15:0] i_period,
   output pcc_pkg::pcc_time_base_t o_tb
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] cnt_q;
   logic up_q;
   logic tick_q;
   assign o_tb = '{count: cnt_q, period: i_period, count_up: up_q, tick: tick_q};
   // Tick every other clock, one count step per tick
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_b) begin
         cnt_q <= 16'h0000;
         up_q <= 1'b1;
         tick_q <= 1'b0;
      end else begin
         tick_q <= !tick_q;
         if (tick_q && i_mode == 2'h0) begin
            cnt_q <= (cnt_q == i_period) ? 16'h0000 : cnt_q + 16'h0001;
         end else if (tick_q) begin
            // Zero up to period and back down
            up_q <= up_q ? (cnt_q != i_period) : (cnt_q == 16'h0000);
            if (up_q && cnt_q != i_period || !up_q && cnt_q == 16'h0000) begin
               cnt_q <= cnt_q + 16'h0001;
            end else begin
               cnt_q <= cnt_q - 16'h0001;
            end
         end
      end
   end
endmodule : pcc_time_base_model

// File: dv/pcc_counter_compare_tb.sv
// Self-checking bench for the counter-compare stage
module pcc_counter_compare_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_sys_clk;
   logic i_rst_b;
   logic [1:0] mode;
   pcc_pkg::pcc_bus_req_t bus;
   pcc_pkg::pcc_time_base_t tb;
   pcc_pkg::pcc_events_t ev;
   logic [15:0] rdata;
   logic [15:0] fine;
   logic [15:0] last_cnt;
   int miscompares;
   int cmp_count;
   pcc_time_base_model i_pcc_time_base_model (.i_sys_clk, .i_rst_b, .i_mode(mode),
      .i_period(16'h0008), .o_tb(tb));
   pcc_counter_compare i_pcc_counter_compare (.i_sys_clk, .i_rst_b, .i_bus(bus),
      .o_rdata(rdata), .i_tb(tb), .o_events(ev), .o_fine_a(fine));
   initial begin
      i_sys_clk = 1'b0;
      forever #50 i_sys_clk = ~i_sys_clk;
   end
   always @(posedge i_sys_clk) if (tb.tick) last_cnt <= tb.count;
   task chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_sys_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_sys_clk);
      bus.wr <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [15:0] e);
      @(posedge i_sys_clk);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_sys_clk);
      bus.rd <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd
   // Counts events and the count that raised each
   task watch(input int n, input logic [15:0] ea, eb, input int xa, xb);
      int na;
      int nb;
      na = 0;
      nb = 0;
      repeat (n) begin
         @(posedge i_sys_clk);
         #1;
         if (ev.match_a_event === 1'b1) begin
            na++;
            chk(last_cnt, ea);
         end
         if (ev.match_b_event === 1'b1) begin
            nb++;
            chk(last_cnt, eb);
         end
      end
      chk(16'(na), 16'(xa));
      chk(16'(nb), 16'(xb));
   endtask : watch
   task t_reset;
      rd(8'h0e, 16'h0000);
      rd(8'h12, 16'h0000);
      rd(8'h14, 16'h0000);
      rd(8'h16, 16'h0000);
   endtask : t_reset
   task t_freeze;
      wr(8'h0e, 16'h000f);
      wr(8'h12, 16'h0005);
      wr(8'h14, 16'h0006);
      rd(8'h12, 16'h0005);
      watch(36, 16'h0000, 16'h0000, 2, 2);
   endtask : t_freeze
   task t_load_points;
      wr(8'h0e, 16'h0003);
      repeat (20) @(posedge i_sys_clk);
      watch(36, 16'h0000, 16'h0006, 2, 2);
      wr(8'h0e, 16'h0009);
      repeat (20) @(posedge i_sys_clk);
      rd(8'h0e, 16'h0009);
      watch(36, 16'h0005, 16'h0006, 2, 2);
   endtask : t_load_points
   task t_updown;
      mode <= 2'h2;
      wr(8'h12, 16'h0003);
      wr(8'h14, 16'h0008);
      repeat (40) @(posedge i_sys_clk);
      watch(64, 16'h0003, 16'h0008, 4, 2);
   endtask : t_updown
   task t_immediate;
      wr(8'h0e, 16'h0053);
      wr(8'h12, 16'h0002);
      wr(8'h14, 16'h0000);
      rd(8'h12, 16'h0002);
      watch(64, 16'h0002, 16'h0000, 4, 2);
   endtask : t_immediate
   task t_fine;
      wr(8'h10, 16'h1234);
      rd(8'h10, 16'h1234);
      chk(fine, 16'h1234);
   endtask : t_fine
   task report_and_stop;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      i_rst_b = 1'b0;
      mode = 2'h0;
      bus = '0;
      miscompares = 0;
      cmp_count = 0;
      repeat (6) @(posedge i_sys_clk);
      i_rst_b <= 1'b1;
      t_reset();
      t_freeze();
      t_load_points();
      t_updown();
      t_immediate();
      t_fine();
      report_and_stop();
   end
endmodule : pcc_counter_compare_tb
